// [core/dmx_data_mem.sv]
`timescale 1ns/100ps
`include "dmx_map.svh"
module dmx_data_mem #(
	parameter int SECTORS = 18
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// cpu data access
	input wire logic acc_rd,
	input wire logic acc_wr,
	input wire logic [12:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	// read answer, one cycle after acc_rd
	output logic [7:0] acc_rdata,
	output logic acc_rvalid,
	// pointer view
	output logic [7:0] pointer_zero,
	output logic [7:0] pointer_one_low,
	output logic [7:0] pointer_one_high,
	output logic [7:0] pointer_two_low,
	output logic [7:0] pointer_two_high
);
	// ----------------------------------------
	// address resolution
	// ----------------------------------------
	logic [7:0] ptr0_ff, ptr1l_ff, ptr1h_ff, ptr2l_ff, ptr2h_ff;
	logic [7:0] loc_direct;
	logic [4:0] sec_direct;
	logic [4:0] eff_sec;
	logic [7:0] eff_loc;
	dmx_pkg::dmx_src_t src;
	logic is_ram, hit_reg, ram_we;
	logic [7:0] ram_q;
	logic [7:0] nxt_rdata;
	logic rd_ram_ff, rd_ram_nohit;
	logic [7:0] reg_q_ff;

	// 13-bit address: sector above, location in low byte [RULE_11] [RULE_08]
	assign loc_direct = acc_addr[7:0];
	assign sec_direct = acc_addr[12:8];

	function automatic dmx_pkg::dmx_src_t decode_src(input logic [12:0] a);
		if (a[12:8] != 5'h00) begin
			decode_src = dmx_pkg::DMX_SRC_DIRECT;
		end else if (a[7:0] == `DMX_OFS_PORT0) begin
			decode_src = dmx_pkg::DMX_SRC_PTR0;
		end else if (a[7:0] == `DMX_OFS_PORT1) begin
			decode_src = dmx_pkg::DMX_SRC_PTR1;
		end else if (a[7:0] == `DMX_OFS_PORT2) begin
			decode_src = dmx_pkg::DMX_SRC_PTR2;
		end else begin
			decode_src = dmx_pkg::DMX_SRC_DIRECT;
		end
	endfunction : decode_src

	assign src = decode_src(acc_addr);

	// redirect port accesses through the pointers [RULE_02]
	always_comb begin
		case (src)
			dmx_pkg::DMX_SRC_PTR0: begin
				eff_sec = 5'h00; // [RULE_03]
				eff_loc = ptr0_ff;
			end
			dmx_pkg::DMX_SRC_PTR1: begin
				eff_sec = ptr1h_ff[4:0]; // [RULE_04] [RULE_05]
				eff_loc = ptr1l_ff; // [RULE_09]
			end
			dmx_pkg::DMX_SRC_PTR2: begin
				eff_sec = ptr2h_ff[4:0]; // [RULE_04] [RULE_05]
				eff_loc = ptr2l_ff; // [RULE_09]
			end
			default: begin
				eff_sec = sec_direct;
				eff_loc = loc_direct;
			end
		endcase
	end

	// direct sector range test, kept ahead of the decode it qualifies
	function automatic logic ptr_ok_direct(input logic [12:0] a);
		ptr_ok_direct = (a[12:8] <= 5'(SECTORS - 1));
	endfunction : ptr_ok_direct

	// ram lives in upper half of sectors 0..17; high bytes with bits 4:0 past 17 miss [RULE_10]
	// high pointer bits 7:5 are ignored, so 20h aliases sector 0: a
	// limitation firmware must respect when it steps a high pointer
	assign is_ram = eff_loc[7] && (eff_sec <= 5'(SECTORS - 1))
		&& (src == dmx_pkg::DMX_SRC_DIRECT ? ptr_ok_direct(acc_addr)
		: 1'b1);

	// pointer registers sit only at sector-0 special locations
	assign hit_reg = (eff_sec == 5'h00) && !eff_loc[7];
	assign ram_we = acc_wr && is_ram;

	dmx_ram #(
		.SECTORS(SECTORS)
	) u_ram (
		.ref_clk(ref_clk),
		.wr_en(ram_we),
		.sector(eff_sec),
		.index(eff_loc[6:0]),
		.wr_data(acc_wdata),
		.rd_data(ram_q)
	);

	// ----------------------------------------
	// pointer registers
	// ----------------------------------------
	// real storage, written directly or through another port [RULE_07]
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ptr0_ff <= `DMX_PTR_RST;
			ptr1l_ff <= `DMX_PTR_RST;
			ptr1h_ff <= `DMX_PTR_RST;
			ptr2l_ff <= `DMX_PTR_RST;
			ptr2h_ff <= `DMX_PTR_RST;
		end else if (acc_wr && hit_reg) begin
			case (eff_loc)
				`DMX_OFS_PTR0: ptr0_ff <= acc_wdata; // [RULE_07]
				`DMX_OFS_PTR1L: ptr1l_ff <= acc_wdata;
				`DMX_OFS_PTR1H: ptr1h_ff <= acc_wdata;
				`DMX_OFS_PTR2L: ptr2l_ff <= acc_wdata;
				`DMX_OFS_PTR2H: ptr2h_ff <= acc_wdata;
				default: ; // ports and unused cells take no write [RULE_06]
			endcase
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// register side read; ports and unused cells give zero [RULE_01] [RULE_06]
	always_comb begin
		nxt_rdata = `DMX_ZERO;
		if (hit_reg) begin
			case (eff_loc)
				`DMX_OFS_PTR0: nxt_rdata = ptr0_ff;
				`DMX_OFS_PTR1L: nxt_rdata = ptr1l_ff;
				`DMX_OFS_PTR1H: nxt_rdata = ptr1h_ff;
				`DMX_OFS_PTR2L: nxt_rdata = ptr2l_ff;
				`DMX_OFS_PTR2H: nxt_rdata = ptr2h_ff;
				default: nxt_rdata = `DMX_ZERO; // [RULE_01]
			endcase
		end
	end

	// remember source so ram and register reads share one latency
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rd_ram_ff <= 1'b0;
			reg_q_ff <= `DMX_ZERO;
			acc_rvalid <= 1'b0;
		end else begin
			rd_ram_ff <= acc_rd && is_ram;
			reg_q_ff <= nxt_rdata;
			acc_rvalid <= acc_rd;
		end
	end

	assign rd_ram_nohit = !rd_ram_ff;
	assign acc_rdata = rd_ram_nohit ? reg_q_ff : ram_q;

	// outputs
	assign pointer_zero = ptr0_ff;
	assign pointer_one_low = ptr1l_ff;
	assign pointer_one_high = ptr1h_ff;
	assign pointer_two_low = ptr2l_ff;
	assign pointer_two_high = ptr2h_ff;

	// ----------------------------------------
	// check shadow
	// ----------------------------------------
	logic [12:0] shd_addr_ff;
	logic [7:0] shd_data_ff;
	logic shd_valid_ff;

	// last ram write, kept only so a later read of that cell can be checked
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			shd_addr_ff <= 13'h0000;
			shd_data_ff <= `DMX_ZERO;
			shd_valid_ff <= 1'b0;
		end else if (ram_we) begin
			shd_addr_ff <= {eff_sec, eff_loc};
			shd_data_ff <= acc_wdata;
			shd_valid_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// zero reads of ports, unused cells and missing sectors
	AST_PORT_READ_ZERO: assert property ( // [RULE_06]
		@(posedge ref_clk) disable iff (!rstn)
		acc_rd && acc_addr == 13'h0002
		&& ptr1h_ff == 8'h00 && ptr1l_ff == 8'h02
		|=> acc_rdata == 8'h00
	) else $error("port self read not zero");
	AST_UNUSED_ZERO: assert property ( // [RULE_01]
		@(posedge ref_clk) disable iff (!rstn)
		acc_rd && acc_addr == 13'h0005 |=> acc_rdata == 8'h00
	) else $error("unused location read not zero");
	AST_LOW_HALF_ZERO: assert property ( // [RULE_01]
		@(posedge ref_clk) disable iff (!rstn)
		acc_rd && acc_addr[12:8] != 5'h00 && !acc_addr[7]
		|=> acc_rdata == 8'h00
	) else $error("low half of a far sector not zero");
	AST_FAR_SECTOR_ZERO: assert property ( // [RULE_10]
		@(posedge ref_clk) disable iff (!rstn)
		acc_rd && acc_addr[12:8] > 5'(SECTORS - 1)
		|=> acc_rdata == 8'h00
	) else $error("direct read past last sector not zero");
	AST_PORT_FAR_ZERO: assert property ( // [RULE_10]
		@(posedge ref_clk) disable iff (!rstn)
		acc_rd && acc_addr == 13'h0002
		&& ptr1h_ff[4:0] > 5'(SECTORS - 1)
		|=> acc_rdata == 8'h00
	) else $error("port read past last sector not zero");

	// pointer storage
	AST_PTR_WRITE: assert property ( // [RULE_07]
		@(posedge ref_clk) disable iff (!rstn)
		acc_wr && acc_addr == 13'h0001 |=> ptr0_ff == $past(acc_wdata)
	) else $error("pointer zero not written");
	AST_PTR1L_WRITE: assert property ( // [RULE_07]
		@(posedge ref_clk) disable iff (!rstn)
		acc_wr && acc_addr == 13'h0003 |=> ptr1l_ff == $past(acc_wdata)
	) else $error("pointer one low not written");
	AST_PTR1H_WRITE: assert property ( // [RULE_07]
		@(posedge ref_clk) disable iff (!rstn)
		acc_wr && acc_addr == 13'h0004 |=> ptr1h_ff == $past(acc_wdata)
	) else $error("pointer one high not written");
	AST_PTR2L_WRITE: assert property ( // [RULE_07]
		@(posedge ref_clk) disable iff (!rstn)
		acc_wr && acc_addr == 13'h000d |=> ptr2l_ff == $past(acc_wdata)
	) else $error("pointer two low not written");
	AST_PTR2H_WRITE: assert property ( // [RULE_07]
		@(posedge ref_clk) disable iff (!rstn)
		acc_wr && acc_addr == 13'h000e |=> ptr2h_ff == $past(acc_wdata)
	) else $error("pointer two high not written");
	AST_PTR_READBACK: assert property ( // [RULE_07]
		@(posedge ref_clk) disable iff (!rstn)
		acc_rd && acc_addr == 13'h000d |=> acc_rdata == $past(ptr2l_ff)
	) else $error("pointer two low readback wrong");
	AST_PTR_HOLD: assert property ( // [RULE_07]
		@(posedge ref_clk) disable iff (!rstn)
		!acc_wr |=> $stable(ptr0_ff) && $stable(ptr1l_ff)
		&& $stable(ptr1h_ff) && $stable(ptr2l_ff)
		&& $stable(ptr2h_ff)
	) else $error("pointer changed without a write");
	AST_UNUSED_NO_STORE: assert property ( // [RULE_07]
		@(posedge ref_clk) disable iff (!rstn)
		acc_wr && acc_addr == 13'h0020 |=> $stable(ptr0_ff)
		&& $stable(ptr1l_ff) && $stable(ptr1h_ff)
		&& $stable(ptr2l_ff) && $stable(ptr2h_ff)
	) else $error("unused location write changed a pointer");

	// redirection through the ports, direct sectors and ram readback
	AST_PORT0_SECTOR0: assert property ( // [RULE_03]
		@(posedge ref_clk) disable iff (!rstn)
		src == dmx_pkg::DMX_SRC_PTR0
		|-> eff_sec == 5'h00 && eff_loc == ptr0_ff
	) else $error("port zero left sector 0");
	AST_PORT1_SECTOR: assert property ( // [RULE_05]
		@(posedge ref_clk) disable iff (!rstn)
		src == dmx_pkg::DMX_SRC_PTR1
		|-> eff_sec == ptr1h_ff[4:0] && eff_loc == ptr1l_ff
	) else $error("port one address wrong");
	AST_PORT2_SECTOR: assert property ( // [RULE_09]
		@(posedge ref_clk) disable iff (!rstn)
		src == dmx_pkg::DMX_SRC_PTR2
		|-> eff_sec == ptr2h_ff[4:0] && eff_loc == ptr2l_ff
	) else $error("port two address wrong");
	AST_DIRECT_SECTOR: assert property ( // [RULE_08]
		@(posedge ref_clk) disable iff (!rstn)
		acc_addr[12:8] != 5'h00 |-> eff_sec == acc_addr[12:8]
	) else $error("direct sector wrong");
	AST_NO_PORT_STORE: assert property ( // [RULE_02]
		@(posedge ref_clk) disable iff (!rstn)
		acc_wr && acc_addr == 13'h000c
		&& ptr2h_ff == 8'h00 && ptr2l_ff == 8'h0c
		|=> $stable(ptr0_ff) && $stable(ptr2l_ff)
	) else $error("port write changed a register");
	AST_PORT_TO_PTR: assert property ( // [RULE_02]
		@(posedge ref_clk) disable iff (!rstn)
		acc_wr && acc_addr == 13'h0002
		&& ptr1h_ff == 8'h00 && ptr1l_ff == 8'h01
		|=> ptr0_ff == $past(acc_wdata)
	) else $error("port write did not reach pointer zero");
	AST_RAM_READBACK: assert property ( // [RULE_02]
		@(posedge ref_clk) disable iff (!rstn)
		acc_rd && is_ram && shd_valid_ff
		&& {eff_sec, eff_loc} == shd_addr_ff
		|=> acc_rdata == $past(shd_data_ff)
	) else $error("ram read did not return last write");

	// ram window and read handshake
	AST_RAM_WINDOW: assert property ( // [RULE_10]
		@(posedge ref_clk) disable iff (!rstn)
		ram_we |-> eff_loc[7] && eff_sec <= 5'h11
	) else $error("ram write outside window");
	AST_READ_NO_WRITE: assert property ( // [RULE_02]
		@(posedge ref_clk) disable iff (!rstn)
		acc_rd && !acc_wr |-> !ram_we
	) else $error("read wrote the ram");
	AST_RVALID_SET: assert property ( // [RULE_02]
		@(posedge ref_clk) disable iff (!rstn)
		acc_rd |=> acc_rvalid
	) else $error("read answer missing");
	AST_RVALID_CLEAR: assert property ( // [RULE_02]
		@(posedge ref_clk) disable iff (!rstn)
		!acc_rd |=> !acc_rvalid
	) else $error("read answer without a read");
endmodule : dmx_data_mem

// [core/dmx_map.svh]
// What this block does
// RULE_01 - A read of an unused special register location returns zero.
// RULE_02 - Access to an indirect port goes to the RAM cell named by its pointer.
// RULE_03 - The first indirect port with its one-byte pointer reaches sector 0 only.
// RULE_04 - The second and third indirect ports with their pointer pairs reach any sector.
// RULE_05 - The sector of a paired-pointer access comes from the pointer high byte.
// RULE_06 - Reading an indirect port itself gives zero and writing it does nothing.
// RULE_07 - The five pointer bytes are real registers that software reads and writes.
// RULE_08 - Direct addressing reaches every sector without the pointers.
// RULE_09 - The location in the sector comes from the pointer low byte.
// RULE_10 - General RAM sits in sectors 0 to 17 at locations 80H to FFH.
// RULE_11 - A 13-bit direct address holds the sector above and location in low byte.
`ifndef DMX_MAP_SVH
`define DMX_MAP_SVH
// ----------------------------------------
// special register locations
// ----------------------------------------
`define DMX_OFS_PORT0 8'h00
`define DMX_OFS_PTR0 8'h01
`define DMX_OFS_PORT1 8'h02
`define DMX_OFS_PTR1L 8'h03
`define DMX_OFS_PTR1H 8'h04
`define DMX_OFS_PORT2 8'h0c
`define DMX_OFS_PTR2L 8'h0d
`define DMX_OFS_PTR2H 8'h0e
// ----------------------------------------
// layout and reset values
// ----------------------------------------
`define DMX_RAM_BASE 8'h80
`define DMX_LAST_SECTOR 5'h11
`define DMX_PTR_RST 8'h00
`define DMX_ZERO 8'h00
`endif

// [core/dmx_pkg.sv]
package dmx_pkg;
	// source of an access, decoded from the address before pointer resolution
	typedef enum logic [1:0] {
		DMX_SRC_DIRECT = 2'h0,
		DMX_SRC_PTR0 = 2'h1,
		DMX_SRC_PTR1 = 2'h3,
		DMX_SRC_PTR2 = 2'h2
	} dmx_src_t;
endpackage : dmx_pkg

// [core/dmx_ram.sv]
`timescale 1ns/100ps
`include "dmx_map.svh"
module dmx_ram #(
	parameter int SECTORS = 18
) (
	// clock
	input wire logic ref_clk,
	// access port
	input wire logic wr_en,
	input wire logic [4:0] sector,
	input wire logic [6:0] index,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data
);
	logic [7:0] mem [SECTORS*128];
	logic [11:0] flat;

	// flat word index: sector times 128 plus location
	assign flat = {sector, index};

	// one write port, synchronous read; contents are not reset
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[flat] <= wr_data;
		end
		rd_data <= mem[flat];
	end
endmodule : dmx_ram

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic acc_rd = 1'b0;
	logic acc_wr = 1'b0;
	logic [12:0] acc_addr = 13'h0000;
	logic [7:0] acc_wdata = 8'h00;
	logic [7:0] acc_rdata;
	logic acc_rvalid;
	logic [7:0] p0, p1l, p1h, p2l, p2h;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	// row: {read, address, data}; data is the expected value on reads
	logic [21:0] rows [26] = '{
		{1'b0, 13'h0001, 8'h90}, {1'b0, 13'h0190, 8'h11},
		{1'b0, 13'h0000, 8'h5a}, {1'b1, 13'h0090, 8'h5a},
		{1'b1, 13'h0190, 8'h11}, {1'b0, 13'h0004, 8'h11},
		{1'b0, 13'h0003, 8'hf0}, {1'b0, 13'h0002, 8'ha5},
		{1'b1, 13'h11f0, 8'ha5}, {1'b1, 13'h0002, 8'ha5},
		{1'b0, 13'h000e, 8'h01}, {1'b0, 13'h000d, 8'h85},
		{1'b0, 13'h0185, 8'h3c}, {1'b1, 13'h000c, 8'h3c},
		{1'b1, 13'h0001, 8'h90}, {1'b1, 13'h0004, 8'h11},
		{1'b1, 13'h000d, 8'h85}, {1'b1, 13'h0020, 8'h00},
		{1'b0, 13'h0020, 8'hff}, {1'b1, 13'h0020, 8'h00},
		{1'b0, 13'h1290, 8'h77}, {1'b1, 13'h1290, 8'h00},
		{1'b1, 13'h0110, 8'h00}, {1'b0, 13'h0001, 8'h00},
		{1'b0, 13'h0000, 8'h66}, {1'b1, 13'h0000, 8'h00}
	};

	// ----------------------------------------
	// clock, design and hang guard
	// ----------------------------------------
	always #20 ref_clk = ~ref_clk;

	dmx_data_mem #(.SECTORS(18)) dmx_data_mem_inst (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.acc_rd(acc_rd),
		.acc_wr(acc_wr),
		.acc_addr(acc_addr),
		.acc_wdata(acc_wdata),
		.acc_rdata(acc_rdata),
		.acc_rvalid(acc_rvalid),
		.pointer_zero(p0),
		.pointer_one_low(p1l),
		.pointer_one_high(p1h),
		.pointer_two_low(p2l),
		.pointer_two_high(p2h)
	);

	// the whole run needs about 100 cycles; a stuck run is cut off
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one idle cycle between accesses keeps each strobe single-driven
	task acc(input logic [21:0] row);
		@(negedge ref_clk);
		acc_rd = row[21];
		acc_wr = !row[21];
		acc_addr = row[20:8];
		acc_wdata = row[7:0];
		@(negedge ref_clk);
		acc_rd = 1'b0;
		acc_wr = 1'b0;
		if (row[21]) begin
			check({7'h00, acc_rvalid}, 8'h01);
			check(acc_rdata, row[7:0]);
		end
	endtask : acc

	task ptrs(input logic [39:0] exp);
		check(p0, exp[39:32]);
		check(p1l, exp[31:24]);
		check(p1h, exp[23:16]);
		check(p2l, exp[15:8]);
		check(p2h, exp[7:0]);
	endtask : ptrs

	task stop_test;
		if (n_mismatch == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(negedge ref_clk);
		rstn = 1'b1;
		ptrs(40'h0000000000);
		check({7'h00, acc_rvalid}, 8'h00);
		// rows cover port redirection, ram in sectors 0, 1 and 17, misses and unused
		// cells; per-row
		foreach (rows[i]) begin
			acc(rows[i]);
		end
		ptrs(40'h00f0118501);
		// ports aimed at themselves or at a pointer
		acc({1'b0, 13'h0004, 8'h00});
		acc({1'b0, 13'h0003, 8'h02});
		acc({1'b1, 13'h0002, 8'h00});
		acc({1'b0, 13'h0002, 8'h44});
		acc({1'b0, 13'h0003, 8'h01});
		acc({1'b0, 13'h0002, 8'h33});
		acc({1'b0, 13'h000e, 8'h00});
		acc({1'b0, 13'h000d, 8'h0c});
		acc({1'b0, 13'h000c, 8'h99});
		acc({1'b1, 13'h0005, 8'h00});
		ptrs(40'h3301000c00);
		// a pair aimed past the last sector drops the access
		acc({1'b0, 13'h0004, 8'h12});
		acc({1'b0, 13'h0003, 8'h90});
		acc({1'b0, 13'h0002, 8'h55});
		acc({1'b1, 13'h0002, 8'h00});
		// port zero ignores the pair high byte and stays in sector 0
		acc({1'b0, 13'h0001, 8'h90});
		acc({1'b1, 13'h0000, 8'h5a});
		// a reset in mid-run must clear every pointer again
		@(negedge ref_clk);
		rstn = 1'b0;
		repeat (2) @(negedge ref_clk);
		rstn = 1'b1;
		ptrs(40'h0000000000);
		check({7'h00, acc_rvalid}, 8'h00);
		// ram keeps its contents across reset; pointers work at once
		acc({1'b1, 13'h0090, 8'h5a});
		acc({1'b0, 13'h0001, 8'h90});
		acc({1'b1, 13'h0000, 8'h5a});
		stop_test();
	end
endmodule : tb_top
